/* File: src/output_pulse_width_and_coarse_phase.sv */
`timescale 1ns/100ps
`default_nettype none
module output_pulse_width_and_coarse_phase
  import out_stage_pkg::*;
#(
  parameter int DIVW = DIV_W
) (
  // synth clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // divider and duty setup
  input wire logic [DIVW-1:0] i_div_value,
  input wire logic [DIVW-1:0] i_duty_high,
  // coarse phase adjust
  input wire logic signed [ADJ_W-1:0] i_adj_value,
  input wire logic i_adj_req,
  output logic o_adj_ready,
  // buffer setup
  input wire logic i_diff_mode,
  input wire logic i_comp_invert,
  input wire logic i_out_enable,
  // outputs
  output logic o_true_pin,
  output logic o_complement_pin,
  output logic o_period_start
);
  pin_if pins ();

  phase_t state_q;
  logic [LEN_W-1:0] rem_q;
  logic [LEN_W-1:0] low_len_q;
  logic pend_q;
  logic signed [ADJ_W-1:0] pend_val_q;
  logic start;
  logic signed [SUM_W-1:0] adj_use, adj_h, adj_l;
  logic signed [SUM_W-1:0] base_h, base_l;
  logic [LEN_W-1:0] high_len, low_len;
  logic adj_on;

  function automatic logic signed [SUM_W-1:0] sat_adj(input logic signed [SUM_W-1:0] v);
    if (v > ADJ_LIMIT) begin
      sat_adj = ADJ_LIMIT;
    end else if (v < -ADJ_LIMIT) begin
      sat_adj = -ADJ_LIMIT;
    end else begin
      sat_adj = v;
    end
  endfunction

  function automatic logic [LEN_W-1:0] phase_len(input logic signed [SUM_W-1:0] v,
                                                 input logic floor2);
    if (floor2 && v < $signed({1'b0, MIN_PHASE})) begin
      phase_len = MIN_PHASE;
    end else if (v < 0) begin
      phase_len = '0;
    end else begin
      phase_len = v[LEN_W-1:0];
    end
  endfunction

  // period ends on the last cycle of low, or of high when low is empty
  assign start = (rem_q == RST_REM) && (state_q == PH_LOW || low_len_q == '0);

  always_comb begin
    adj_use = pend_q ? SUM_W'(pend_val_q) : '0;
    adj_on = pend_q && (pend_val_q != '0);
    if (i_duty_high == '0) begin
      base_h = SUM_W'((SUM_W'(i_div_value) + 1) >>> 1);
      adj_h = adj_use >>> 1;
      adj_l = adj_use - adj_h;
    end else begin
      base_h = SUM_W'(i_duty_high);
      adj_h = '0;
      adj_l = adj_use;
    end
    base_l = SUM_W'(i_div_value) - base_h;
    if (base_h == '0) begin
      base_h = SUM_W'(1);
    end
    high_len = phase_len(base_h + sat_adj(adj_h), adj_on && i_duty_high == '0);
    low_len = phase_len(base_l + sat_adj(adj_l), adj_on);
    if (high_len == '0) begin
      high_len = RST_REM;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q <= PH_LOW;
      rem_q <= RST_REM;
      low_len_q <= RST_LOW;
    end else if (start) begin
      state_q <= PH_HIGH;
      rem_q <= high_len;
      low_len_q <= low_len;
    end else if (rem_q == RST_REM) begin
      state_q <= PH_LOW;
      rem_q <= low_len_q;
    end else begin
      rem_q <= rem_q - RST_REM;
    end
  end

  // one pending adjust; a new request in the consume cycle stays pending
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pend_q <= 1'b0;
      pend_val_q <= RST_ADJ;
    end else if (i_adj_req && o_adj_ready) begin
      pend_q <= 1'b1;
      pend_val_q <= i_adj_value;
    end else if (start) begin
      pend_q <= 1'b0;
    end
  end

  assign o_adj_ready = !pend_q || start;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_period_start <= 1'b0;
    end else begin
      o_period_start <= start;
    end
  end

  assign pins.shaped_clk = (state_q == PH_HIGH);
  assign pins.diff_mode = i_diff_mode;
  assign pins.comp_invert = i_comp_invert;
  assign pins.out_enable = i_out_enable;

  // one driver instance drives both pins from the same shaped clock and buffer setup
  output_pin_driver u_pin_driver (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .pins(pins),
    .o_true_pin(o_true_pin),
    .o_complement_pin(o_complement_pin)
  );

  a_pulse_rises: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    start |=> (state_q == PH_HIGH && o_period_start))
    else $error("period start did not raise output");
  a_duty_high_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && i_duty_high != '0) |=> (rem_q == LEN_W'($past(i_duty_high))))
    else $error("duty mode high time wrong");
  a_min_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && adj_on) |=>
    (low_len_q >= MIN_PHASE && (rem_q >= MIN_PHASE || $past(i_duty_high) != '0)))
    else $error("adjusted phase below two cycles");
  a_fifty_split: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_duty_high == '0) |-> (adj_l - adj_h == 0 || adj_l - adj_h == 1))
    else $error("50/50 split uneven");
  a_adj_consumed: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && pend_q && !i_adj_req) |=> !pend_q)
    else $error("adjust not applied in one period");
  a_plain_period: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && !pend_q && i_duty_high == '0 && i_div_value >= 2) |=>
    (rem_q + low_len_q == LEN_W'($past(i_div_value))))
    else $error("divided period length wrong");
  a_high_to_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == PH_HIGH && rem_q == RST_REM && low_len_q != '0) |=> (state_q == PH_LOW))
    else $error("high phase did not end on count");

  // adjust handshake
  a_ready_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !pend_q |-> o_adj_ready)
    else $error("ready low with nothing pending");
  a_ready_busy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (pend_q && !start) |-> !o_adj_ready)
    else $error("ready high while adjust pending");

  a_req_taken: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_adj_req && o_adj_ready) |=> (pend_q && pend_val_q == $past(i_adj_value)))
    else $error("accepted adjust not held");
  a_pend_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (pend_q && !start) |=> (pend_q && $stable(pend_val_q)))
    else $error("pending adjust lost or changed");

  // phase lengths
  a_duty_low_adj: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && pend_q && i_duty_high != '0 && i_div_value > i_duty_high &&
     pend_val_q > 0 && pend_val_q <= ADJ_LIMIT) |=>
    (rem_q == LEN_W'($past(i_duty_high)) && low_len_q == LEN_W'($past(i_div_value)) -
     LEN_W'($past(i_duty_high)) + LEN_W'($past(pend_val_q))))
    else $error("duty mode adjust not in low phase");

  a_plain_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && !pend_q && i_duty_high == '0 && i_div_value >= 2) |=>
    (rem_q == ((LEN_W'($past(i_div_value)) + RST_REM) >> 1)))
    else $error("50/50 high time wrong");
  a_zero_adj: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (start && pend_q && pend_val_q == '0 && i_duty_high == '0 && i_div_value >= 2) |=>
    (rem_q + low_len_q == LEN_W'($past(i_div_value))))
    else $error("zero adjust changed period");

  // phase counter
  a_count_down: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rem_q != RST_REM) |=> (rem_q == $past(rem_q) - RST_REM))
    else $error("phase counter skipped");
  a_state_steady: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rem_q != RST_REM) |=> $stable(state_q))
    else $error("phase changed before count ran out");

  // pins
  a_pin_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_out_enable |=> (o_true_pin == $past(state_q == PH_HIGH)))
    else $error("true pin does not follow shaped clock");
  a_pins_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !i_out_enable |=> (!o_true_pin && !o_complement_pin))
    else $error("disabled pins not low");
endmodule : output_pulse_width_and_coarse_phase
`default_nettype wire

/* File: src/out_stage_pkg.sv */
package out_stage_pkg;
  localparam int DIV_W = 32;
  localparam int ADJ_W = 34;
  localparam int LEN_W = 35;
  localparam int SUM_W = 36;
  localparam logic [LEN_W-1:0] MIN_PHASE = 35'h000000002;
  localparam logic signed [SUM_W-1:0] ADJ_LIMIT = 36'sh100000000;
  localparam logic [LEN_W-1:0] RST_REM = 35'h000000001;
  localparam logic [LEN_W-1:0] RST_LOW = 35'h000000001;
  localparam logic signed [ADJ_W-1:0] RST_ADJ = 34'sh000000000;
  typedef enum logic {PH_HIGH, PH_LOW} phase_t;
endpackage : out_stage_pkg

/* File: src/pin_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pin_if;
  logic shaped_clk;
  logic diff_mode;
  logic comp_invert;
  logic out_enable;
  modport src (output shaped_clk, output diff_mode, output comp_invert, output out_enable);
  modport drv (input shaped_clk, input diff_mode, input comp_invert, input out_enable);
endinterface : pin_if
`default_nettype wire

/* File: src/output_pin_driver.sv */
`timescale 1ns/100ps
`default_nettype none
module output_pin_driver (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // shaped clock and buffer setup
  pin_if.drv pins,
  // pins
  output logic o_true_pin,
  output logic o_complement_pin
);
  logic comp_d;

  always_comb begin
    if (pins.diff_mode) begin
      comp_d = ~pins.shaped_clk;
    end else if (pins.comp_invert) begin
      comp_d = ~pins.shaped_clk;
    end else begin
      comp_d = pins.shaped_clk;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_true_pin <= 1'b0;
      o_complement_pin <= 1'b0;
    end else if (!pins.out_enable) begin
      o_true_pin <= 1'b0;
      o_complement_pin <= 1'b0;
    end else begin
      o_true_pin <= pins.shaped_clk;
      o_complement_pin <= comp_d;
    end
  end

  a_diff_pair: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (pins.out_enable && pins.diff_mode) |=> (o_complement_pin == ~o_true_pin))
    else $error("differential pins not complementary");
  a_se_copy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (pins.out_enable && !pins.diff_mode && !pins.comp_invert) |=>
    (o_complement_pin == o_true_pin))
    else $error("single-ended copies differ");
  a_se_invert: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (pins.out_enable && !pins.diff_mode && pins.comp_invert) |=>
    (o_complement_pin != o_true_pin))
    else $error("inverted complement pin not inverted");
endmodule : output_pin_driver
`default_nettype wire

/* File: test/clock_sink_model.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_sink_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // received clock
  input wire logic i_pin,
  // measured period
  output logic o_valid,
  output logic [31:0] o_hi,
  output logic [31:0] o_lo
);
  logic prev_q;
  logic seen_q;
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  // reports high and low cycle counts at each rising edge of the pin after the first
  always_ff @(posedge i_core_clk) begin
    prev_q <= i_pin;
    o_valid <= 1'b0;
    if (!i_rst_b) begin
      seen_q <= 1'b0;
      hi_q <= 32'h0;
      lo_q <= 32'h0;
    end else if (i_pin && !prev_q) begin
      o_valid <= seen_q;
      o_hi <= hi_q;
      o_lo <= lo_q;
      seen_q <= 1'b1;
      hi_q <= 32'h1;
      lo_q <= 32'h0;
    end else if (i_pin) begin
      hi_q <= hi_q + 32'h1;
    end else begin
      lo_q <= lo_q + 32'h1;
    end
  end
endmodule // clock_sink_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import out_stage_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [DIV_W-1:0] div = 32'h4;
  logic [DIV_W-1:0] duty = 32'h0;
  logic signed [ADJ_W-1:0] adj = 34'sh0;
  logic req = 1'b0;
  logic diff = 1'b0;
  logic inv = 1'b1;
  logic oen = 1'b1;
  logic ready, tpin, cpin, p_valid, pstart;
  logic ps_prev = 1'b0;
  logic tp_prev = 1'b0;
  logic [31:0] p_hi, p_lo;
  logic [63:0] note_q[$];
  int err_count = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  output_pulse_width_and_coarse_phase output_pulse_width_and_coarse_phase_i (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_div_value(div), .i_duty_high(duty),
    .i_adj_value(adj), .i_adj_req(req), .o_adj_ready(ready), .i_diff_mode(diff),
    .i_comp_invert(inv), .i_out_enable(oen), .o_true_pin(tpin),
    .o_complement_pin(cpin), .o_period_start(pstart));
  clock_sink_model clock_sink_model_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_pin(tpin),
    .o_valid(p_valid), .o_hi(p_hi), .o_lo(p_lo));
  task automatic fail(input string msg);
    $display("wrong value at %0t: %s", $time, msg);
    err_count++;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_period(input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) fail($sformatf("high/low %0d/%0d, expected %0d/%0d",
      got[63:32], got[31:0], exp[63:32], exp[31:0]));
  endtask
  task automatic cmp_pin(input logic exp, input logic got);
    checks++;
    if (got !== exp) fail("output pin level");
  endtask
  task automatic next_period();
    int n;
    n = 0;
    while (p_valid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        fail("no period seen");
        conclude();
      end
    end
    @(negedge clk);
  endtask
  task automatic setup(input int d, input int h);
    div = DIV_W'(d);
    duty = DIV_W'(h);
    repeat (3) next_period();
  endtask
  task automatic note(input int h, input int l);
    note_q.push_back({32'(h), 32'(l)});
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while (note_q.size() > 0) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        fail("periods missing");
        conclude();
      end
    end
    $display("test %s done", name);
  endtask
  task automatic adjust(input logic signed [ADJ_W-1:0] v);
    int n;
    n = 0;
    @(negedge clk);
    adj = v;
    req = 1'b1;
    while (ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        fail("adjust never taken");
        conclude();
      end
    end
    @(negedge clk);
    req = 1'b0;
  endtask
  // compares each measured period with the oldest note while notes remain
  always @(negedge clk) begin
    if (p_valid === 1'b1 && note_q.size() > 0) cmp_period(note_q.pop_front(), {p_hi, p_lo});
    if (rst_b && tpin === 1'b1 && tp_prev === 1'b0) cmp_pin(1'b1, ps_prev);
    ps_prev = pstart;
    tp_prev = tpin;
  end
  initial begin
    int d, h;
    void'($urandom(76));
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    setup(4, 0);
    note(2, 2);
    note(4, 3);
    setup(7, 0);
    note(4, 3);
    drain("plain clock");
    setup(10, 3);
    next_period();
    note(3, 7);
    note(3, 12);
    note(3, 3);
    note(3, 2);
    note(3, 7);
    adjust(34'sh5);
    adjust(-34'sh4);
    adjust(34'sh200000000);
    drain("pulse adjust");
    setup(10, 0);
    next_period();
    note(5, 5);
    note(6, 7);
    note(3, 4);
    note(5, 5);
    adjust(34'sh3);
    adjust(-34'sh3);
    adjust(34'sh0);
    drain("clock adjust");
    for (int i = 0; i < 4; i++) begin
      d = 5 + $urandom_range(0, 59);
      h = $urandom_range(0, d - 1);
      setup(d, h);
      note(h == 0 ? (d + 1) / 2 : h, h == 0 ? d / 2 : d - h);
      drain("random setup");
    end
    for (int m = 0; m < 4; m++) begin
      diff = (m == 0);
      inv = (m == 2);
      oen = (m != 3);
      repeat (3) @(negedge clk);
      repeat (12) begin
        @(negedge clk);
        cmp_pin(m == 3 ? 1'b0 : (m == 1 ? tpin : ~tpin), cpin);
        if (m == 3) cmp_pin(1'b0, tpin);
      end
    end
    $display("test pin modes done");
    conclude();
  end
endmodule // tb
`default_nettype wire
